// file: csp_params.svh
// Register map, reset values and write masks of the converter serial port.
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH

// ==========================================================
// Register byte addresses
`define CSP_A_CTRL1   12'h000
`define CSP_A_CTRL2   12'h004
`define CSP_A_CLKDIV  12'h008
`define CSP_A_STATUS  12'h00C
`define CSP_A_RXSLOT  12'h010
`define CSP_A_TXSLOT  12'h014
// Buffer windows: address bits 11:4, word index in bits 3:2.
`define CSP_A_RXBUF   8'h02
`define CSP_A_TXBUF   8'h03

// ==========================================================
// Reset values and writable bits
`define CSP_RST16     16'h0000
`define CSP_RST12     12'h000
`define CSP_CTRL1_WM  16'hAFE3
`define CSP_CTRL2_WM  16'h0DEF
`define CSP_CLKDIV_WM 16'h0FFF
`define CSP_STAT_CLR  16'h000A

// ==========================================================
// Engine constants
`define CSP_MSB       4'hF
`define CSP_ONE10     10'h001
`define CSP_ZERO10    10'h000

`endif

// file: converter_serial_port_pkg.sv
// Types shared by the converter serial port.
package converter_serial_port_pkg;

    // ==========================================================
    // Control register one layout.
    typedef struct packed {
        logic       port_enable;
        logic       rsv14;
        logic       idle_stop;
        logic       rsv12;
        logic       loopback_enable;
        logic       clock_direction;
        logic       clock_edge_select;
        logic       sync_direction;
        logic       underflow_mode;
        logic       output_idle_mode;
        logic       data_justify;
        logic [2:0] rsv4_2;
        logic [1:0] sync_mode;
    } ctrl_one_t;

    // ==========================================================
    // Control register two layout.
    typedef struct packed {
        logic [3:0] rsv15_12;
        logic [1:0] buffer_length;
        logic       rsv9;
        logic [3:0] frame_length;
        logic       rsv4;
        logic [3:0] word_size;
    } ctrl_two_t;

    // ==========================================================
    // Status register layout.
    typedef struct packed {
        logic [3:0] rsv15_12;
        logic [3:0] slot;
        logic [3:0] rsv7_4;
        logic       rx_overflow;
        logic       rx_full;
        logic       tx_underflow;
        logic       tx_empty;
    } status_t;

    // ==========================================================
    // Frame sync modes.
    typedef enum logic [1:0] {
        SYNC_MULTI = 2'h0,
        SYNC_I2S   = 2'h1,
        SYNC_AC16  = 2'h2,
        SYNC_AC20  = 2'h3
    } sync_mode_t;

    // ==========================================================
    // Serial engine states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_RUN  = 3'h4
    } eng_state_t;

endpackage

// file: converter_serial_port.sv
// Converter serial port: APB registers, shadow buffers and serial engine.
// Function
// - Words to 16 bits, 16 slots, 256-bit frame.
// - Buffer length code selects one to four words.
// - Clock direction makes bit clock input or output.
// - Serial out drives data, else float or zero.
// - Serial in pin is input only.
// - Sync direction makes frame sync input or output.
// - Received words left justified, low bits zero.
// - Short transmit words use buffer upper bits.
// - One 16-bit shift register, MSB first.
// - Shared 2-bit word counter addresses both buffers.
// - Engine works on shadow buffer copies.
// - Enable bit switches port and pin control.
// - Idle-stop bit halts port in idle.
// - Loopback routes serial out to serial in.
// - Edge select picks launch and sample edges.
// - Underflow resends last word or zeros.
// - Justify bit starts data with or after sync.
// - Sync mode selects I2S framing; multi and both AC-Link codes frame alike.
// - Frame length code plus one words.
// - Word size code plus one bits.
//
// Our own choices: the address map and the APB slave port.
`include "csp_params.svh"
`timescale 1ns/1ns
`default_nettype none

module converter_serial_port #(
    parameter int AW    = 12,
    parameter int WORDS = 4
) (
    // APB slave.
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output var  logic [31:0]   prdata,
    output var  logic          pready,
    output var  logic          pslverr,
    // Processor power state.
    input  wire logic          cpu_idle,
    // Bit clock pin.
    input  wire logic          bit_clk_pin_i,
    output var  logic          bit_clk_pin_o,
    output var  logic          bit_clk_pin_oe_n,
    // Frame sync pin.
    input  wire logic          frame_sync_pin_i,
    output var  logic          frame_sync_pin_o,
    output var  logic          frame_sync_pin_oe_n,
    // Serial data pins.
    input  wire logic          serial_in_pin_i,
    output var  logic          serial_out_pin_o,
    output var  logic          serial_out_pin_oe_n
);

    // ==========================================================
    // Registers and state.
    converter_serial_port_pkg::ctrl_one_t  c1_q;
    converter_serial_port_pkg::ctrl_two_t  c2_q;
    converter_serial_port_pkg::status_t    st;
    converter_serial_port_pkg::eng_state_t state_q;
    logic [11:0] div_q;
    logic [11:0] bcg_q;
    logic [15:0] rse_q;
    logic [15:0] tse_q;
    logic [15:0] rx_buf_q [WORDS];
    logic [15:0] tx_buf_q [WORDS];
    logic [15:0] rx_sh_q  [WORDS];
    logic [15:0] tx_sh_q  [WORDS];
    logic        rov_q, rful_q, tunf_q, tmpty_q, txwr_q;
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q;
    logic [2:0]  sck_s, fs_s;
    logic [1:0]  sdi_s;
    logic        sck_q, lv_q, fs_prev_q, start_pend_q;
    logic [15:0] sh_q;
    logic [3:0]  bitc_q, slot_q;
    logic [1:0]  wcnt_q;
    logic [9:0]  fpos_q;
    logic        tx_act_q;
    logic        sdo_q, sdo_oe_n_q, fs_o_q, fs_oe_n_q, sck_oe_n_q;

    // ==========================================================
    // Bus decode and read mux.
    logic        acc, wr, rd_done, hit, rxw, txw;
    logic [1:0]  bidx;
    logic [31:0] rd_d;

    assign acc  = psel & penable & pready_q;
    assign wr   = acc & pwrite;
    assign rxw  = paddr[11:4] == `CSP_A_RXBUF;
    assign txw  = paddr[11:4] == `CSP_A_TXBUF;
    assign bidx = paddr[3:2];
    assign rd_done = acc & ~pwrite & rxw;

    always_comb begin
        st          = '0;
        st.slot     = slot_q;
        st.rx_overflow  = rov_q;
        st.rx_full      = rful_q;
        st.tx_underflow = tunf_q;
        st.tx_empty     = tmpty_q;
        rd_d = '0;
        hit  = 1'b1;
        if (rxw) begin
            rd_d[15:0] = rx_buf_q[bidx];
        end else if (txw) begin
            rd_d[15:0] = tx_buf_q[bidx];
        end else begin
            case (paddr)
                `CSP_A_CTRL1:  rd_d[15:0] = c1_q;
                `CSP_A_CTRL2:  rd_d[15:0] = c2_q;
                `CSP_A_CLKDIV: rd_d[11:0] = bcg_q;
                `CSP_A_STATUS: rd_d[15:0] = st;
                `CSP_A_RXSLOT: rd_d[15:0] = rse_q;
                `CSP_A_TXSLOT: rd_d[15:0] = tse_q;
                default:       hit = 1'b0;
            endcase
        end
    end

    // One wait state; data captured in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~hit;
            if (psel & ~penable) begin
                prdata_q <= rd_d;
            end
        end
    end

    // ==========================================================
    // Control registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c1_q  <= `CSP_RST16;
            c2_q  <= `CSP_RST16;
            bcg_q <= `CSP_RST12;
            rse_q <= `CSP_RST16;
            tse_q <= `CSP_RST16;
        end else if (wr) begin
            case (paddr)
                `CSP_A_CTRL1:  c1_q  <= pwdata[15:0] & `CSP_CTRL1_WM;
                `CSP_A_CTRL2:  c2_q  <= pwdata[15:0] & `CSP_CTRL2_WM;
                `CSP_A_CLKDIV: bcg_q <= pwdata[11:0];
                `CSP_A_RXSLOT: rse_q <= pwdata[15:0];
                `CSP_A_TXSLOT: tse_q <= pwdata[15:0];
                default:       ;
            endcase
        end
    end

    // ==========================================================
    // Pin synchronisers and bit clock edges.
    logic en, run, lv, rise, fall, launch, smpl, din, tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_s <= '0;
            fs_s  <= '0;
            sdi_s <= '0;
        end else begin
            sck_s <= {sck_s[1:0], bit_clk_pin_i};
            fs_s  <= {fs_s[1:0], frame_sync_pin_i};
            sdi_s <= {sdi_s[0], serial_in_pin_i};
        end
    end

    assign en   = c1_q.port_enable;
    assign run  = en & ~(c1_q.idle_stop & cpu_idle);
    assign tick = div_q == bcg_q;
    assign lv   = c1_q.clock_direction ? sck_s[1] : sck_q;
    assign rise = run & lv & ~lv_q;
    assign fall = run & ~lv & lv_q;
    assign launch = c1_q.clock_edge_select ? fall : rise;
    assign smpl   = c1_q.clock_edge_select ? rise : fall;
    assign din = c1_q.loopback_enable ? sdo_q : sdi_s[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= `CSP_RST12;
            sck_q <= 1'b0;
            lv_q  <= 1'b0;
        end else begin
            lv_q <= run ? lv : 1'b0;
            if (!run || c1_q.clock_direction) begin
                div_q <= `CSP_RST12;
                sck_q <= 1'b0;
            end else if (tick) begin
                div_q <= `CSP_RST12;
                sck_q <= ~sck_q;
            end else begin
                div_q <= div_q + 12'h001;
            end
        end
    end

    // ==========================================================
    // Frame timing.
    logic [9:0] fbits;
    logic       i2s, int_sync, frame_go, slot_last, word_end, slot_en, swap;
    logic [15:0] load, rx_word;

    assign fbits = ({6'h00, c2_q.frame_length} + `CSP_ONE10)
                 * ({6'h00, c2_q.word_size} + `CSP_ONE10);
    assign i2s = c1_q.sync_mode == converter_serial_port_pkg::SYNC_I2S;
    assign int_sync = ~c1_q.sync_direction;
    assign frame_go = launch & (int_sync ? fpos_q == `CSP_ZERO10 : start_pend_q);
    assign slot_last = slot_q == c2_q.frame_length;
    assign word_end  = smpl & (state_q == converter_serial_port_pkg::ST_RUN)
                     & (bitc_q == c2_q.word_size);
    assign slot_en   = rse_q[slot_q] | tse_q[slot_q];
    assign swap      = word_end & slot_en & (wcnt_q == c2_q.buffer_length);
    // take upper bits of transmit word
    assign load      = tse_q[slot_q] ? tx_sh_q[wcnt_q] : `CSP_RST16;
    assign rx_word   = {sh_q[14:0], din} << (`CSP_MSB - c2_q.word_size);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fpos_q <= `CSP_ZERO10;
            fs_o_q <= 1'b0;
        end else if (!run) begin
            fpos_q <= `CSP_ZERO10;
            fs_o_q <= 1'b0;
        end else if (launch) begin
            fpos_q <= (fpos_q + `CSP_ONE10 >= fbits) ? `CSP_ZERO10 : fpos_q + `CSP_ONE10;
            fs_o_q <= i2s ? (fpos_q >= (fbits >> 1)) : (fpos_q == `CSP_ZERO10);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_prev_q    <= 1'b0;
            start_pend_q <= 1'b0;
        end else if (!run) begin
            fs_prev_q    <= 1'b0;
            start_pend_q <= 1'b0;
        end else begin
            if (smpl) begin
                fs_prev_q <= fs_s[1];
            end
            if (smpl && (i2s ? (fs_prev_q & ~fs_s[1]) : (fs_s[1] & ~fs_prev_q))) begin
                start_pend_q <= 1'b1;
            end else if (launch) begin
                start_pend_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Serial engine.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= converter_serial_port_pkg::ST_IDLE;
            bitc_q   <= '0;
            slot_q   <= '0;
            sh_q     <= `CSP_RST16;
            tx_act_q <= 1'b0;
        end else if (!en) begin
            state_q  <= converter_serial_port_pkg::ST_IDLE;
            bitc_q   <= '0;
            slot_q   <= '0;
            tx_act_q <= 1'b0;
        end else begin
            if (smpl && state_q == converter_serial_port_pkg::ST_RUN) begin
                sh_q <= {sh_q[14:0], din};
            end
            if (launch) begin
                case (state_q)
                    converter_serial_port_pkg::ST_IDLE,
                    converter_serial_port_pkg::ST_WAIT: begin
                        if ((frame_go && c1_q.data_justify) ||
                            state_q == converter_serial_port_pkg::ST_WAIT) begin
                            state_q  <= converter_serial_port_pkg::ST_RUN;
                            slot_q   <= '0;
                            bitc_q   <= '0;
                            sh_q     <= tse_q[0] ? tx_sh_q[wcnt_q] : `CSP_RST16;
                            tx_act_q <= tse_q[0];
                        end else if (frame_go) begin
                            state_q <= converter_serial_port_pkg::ST_WAIT;
                        end
                    end
                    converter_serial_port_pkg::ST_RUN: begin
                        if (bitc_q != c2_q.word_size) begin
                            bitc_q <= bitc_q + 4'h1;
                        end else if (frame_go && c1_q.data_justify) begin
                            slot_q   <= '0;
                            bitc_q   <= '0;
                            sh_q     <= tse_q[0] ? tx_sh_q[wcnt_q] : `CSP_RST16;
                            tx_act_q <= tse_q[0];
                        end else if (frame_go) begin
                            state_q  <= converter_serial_port_pkg::ST_WAIT;
                            tx_act_q <= 1'b0;
                        end else if (slot_last) begin
                            state_q  <= converter_serial_port_pkg::ST_IDLE;
                            tx_act_q <= 1'b0;
                        end else begin
                            slot_q   <= slot_q + 4'h1;
                            bitc_q   <= '0;
                            sh_q     <= tse_q[slot_q + 4'h1] ? tx_sh_q[wcnt_q] : `CSP_RST16;
                            tx_act_q <= tse_q[slot_q + 4'h1];
                        end
                    end
                    default: state_q <= converter_serial_port_pkg::ST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wcnt_q <= '0;
        end else if (!en) begin
            wcnt_q <= '0;
        end else if (word_end && slot_en) begin
            wcnt_q <= swap ? 2'h0 : wcnt_q + 2'h1;
        end
    end

    // ==========================================================
    // Shadow buffers and status.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < WORDS; i++) begin
                rx_sh_q[i]  <= `CSP_RST16;
                tx_sh_q[i]  <= `CSP_RST16;
                rx_buf_q[i] <= `CSP_RST16;
                tx_buf_q[i] <= `CSP_RST16;
            end
        end else begin
            if (word_end && rse_q[slot_q]) begin
                rx_sh_q[wcnt_q] <= rx_word;
            end
            for (int i = 0; i < WORDS; i++) begin
                if (swap) begin
                    rx_buf_q[i] <= (i[1:0] == wcnt_q && rse_q[slot_q]) ? rx_word : rx_sh_q[i];
                    tx_sh_q[i] <= (txwr_q || c1_q.underflow_mode) ? tx_buf_q[i] : `CSP_RST16;
                end
                if (wr && txw && bidx == i[1:0]) begin
                    tx_buf_q[i] <= pwdata[15:0];
                end
            end
        end
    end

    // Flags: hardware set wins over software clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rov_q   <= 1'b0;
            rful_q  <= 1'b0;
            tunf_q  <= 1'b0;
            tmpty_q <= 1'b1;
            txwr_q  <= 1'b0;
        end else begin
            rov_q   <= (swap & rful_q) |
                       (rov_q & ~(wr && paddr == `CSP_A_STATUS && pwdata[3]));
            rful_q  <= swap | (rful_q & ~rd_done);
            tunf_q  <= (swap & ~txwr_q) |
                       (tunf_q & ~(wr && paddr == `CSP_A_STATUS && pwdata[1]));
            tmpty_q <= swap | (tmpty_q & ~(wr & txw));
            txwr_q  <= (wr & txw) | (txwr_q & ~swap);
        end
    end

    // ==========================================================
    // Pin drivers, enables low while driving.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdo_q       <= 1'b0;
            sdo_oe_n_q  <= 1'b1;
            fs_oe_n_q   <= 1'b1;
            sck_oe_n_q  <= 1'b1;
        end else begin
            sdo_q      <= tx_act_q & sh_q[15];
            sdo_oe_n_q <= ~(en & (tx_act_q | ~c1_q.output_idle_mode));
            fs_oe_n_q  <= ~(en & ~c1_q.sync_direction);
            sck_oe_n_q <= ~(en & ~c1_q.clock_direction);
        end
    end

    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign bit_clk_pin_o       = sck_q;
    assign bit_clk_pin_oe_n    = sck_oe_n_q;
    assign frame_sync_pin_o    = fs_o_q;
    assign frame_sync_pin_oe_n = fs_oe_n_q;
    assign serial_out_pin_o    = sdo_q;
    assign serial_out_pin_oe_n = sdo_oe_n_q;

endmodule

`default_nettype wire

// file: csp_asserts.sv
// Port checker for the converter serial port.
`timescale 1ns/1ns
`default_nettype none

module csp_asserts #(
    parameter int AW = 12
) (
    // APB side.
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    // Link pins.
    input wire logic          bit_clk_pin_o,
    input wire logic          bit_clk_pin_oe_n,
    input wire logic          serial_out_pin_o,
    input wire logic          serial_out_pin_oe_n
);
    // ==========================================================
    // Register access.
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held too long");
    AST_READY_ACCESS: assert property (pready |-> psel && penable && $past(penable))
        else $error("pready outside access phase");
    AST_ONE_WAIT: assert property (psel && !penable ##1 psel && penable |=> pready)
        else $error("answer not in second access cycle");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_UNMAPPED: assert property (pready && paddr == 12'h040 |-> pslverr)
        else $error("unmapped access not refused");
    AST_MAPPED: assert property (pready && paddr == 12'h000 |-> !pslverr)
        else $error("control access refused");
    AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read data not zero");

    // ==========================================================
    // Link pins.
    AST_BCLK_HELD: assert property (bit_clk_pin_oe_n[*3] |-> $stable(bit_clk_pin_o))
        else $error("bit clock moves while released");
    AST_SOUT_STANDS: assert property (!serial_out_pin_oe_n && $changed(serial_out_pin_o)
        |=> ($stable(serial_out_pin_o) || serial_out_pin_oe_n)[*2])
        else $error("serial bit too short");
endmodule

bind converter_serial_port csp_asserts #(.AW(AW)) csp_asserts_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .bit_clk_pin_o, .bit_clk_pin_oe_n, .serial_out_pin_o, .serial_out_pin_oe_n
);

`default_nettype wire

// file: codec_model.sv
// Far-side codec model for the converter serial port link.
`timescale 1ns/1ns
`default_nettype none

module codec_model (
    // Link pins.
    input  wire logic        dev_clk,
    input  wire logic        dev_sync,
    input  wire logic        data_in,
    output var  logic        data_out,
    output wire logic        link_clk,
    output wire logic        link_sync,
    // Bench control.
    input  wire logic        ext,
    input  wire logic        inv,
    input  wire logic [4:0]  bits,
    input  wire logic [15:0] word,
    output var  logic [15:0] heard
);
    logic        mclk = 1'h0;
    logic        msync = 1'h0;
    logic [15:0] sh = 16'h0000;
    wire         sclk;
    int          cnt = 15;

    initial begin
        #13;
        forever #200 mclk = ext ? !mclk : 1'h0;
    end
    assign link_clk = ext ? mclk : dev_clk;
    assign link_sync = ext ? msync : dev_sync;
    assign sclk = link_clk ^ inv;

    always @(negedge sclk) begin
        cnt = (link_sync && !ext) ? 0 : (cnt + 1) % bits;
        if (cnt == 0) sh = 16'h0000;
        sh[15 - cnt] = data_in;
        if (cnt == bits - 1) heard = sh;
    end

    always @(posedge sclk) begin
        data_out <= word[15 - (cnt + 1) % bits];
        msync <= ext && ((cnt + 1) % bits == bits - 1);
    end
endmodule

`default_nettype wire

// file: tb_converter_serial_port.sv
// Self-checking bench for the converter serial port.
`include "csp_params.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_converter_serial_port;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cpu_idle = 1'h0;
    logic        ext = 1'h0;
    logic        inv = 1'h0;
    logic [4:0]  bits = 5'h10;
    logic [15:0] heard;
    logic        lclk, lsync, sdi, bclk_o, bclk_oe_n, fs_o, fs_oe_n, sdo, sdo_oe_n;
    logic [31:0] rdat;
    logic        rerr;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    localparam logic [11:0] RX0 = {`CSP_A_RXBUF, 4'h0};
    localparam logic [11:0] TX0 = {`CSP_A_TXBUF, 4'h0};

    always #25 pclk = ~pclk;

    converter_serial_port converter_serial_port_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_idle(cpu_idle), .bit_clk_pin_i(lclk),
        .bit_clk_pin_o(bclk_o), .bit_clk_pin_oe_n(bclk_oe_n), .frame_sync_pin_i(lsync),
        .frame_sync_pin_o(fs_o), .frame_sync_pin_oe_n(fs_oe_n), .serial_in_pin_i(sdi),
        .serial_out_pin_o(sdo), .serial_out_pin_oe_n(sdo_oe_n));

    codec_model codec_model_i (
        .dev_clk(bclk_o), .dev_sync(fs_o), .data_in(sdo), .data_out(sdi),
        .link_clk(lclk), .link_sync(lsync), .ext(ext), .inv(inv), .bits(bits),
        .word(16'h3C5A), .heard(heard));

    // ==========================================================
    // Shared tasks.
    task finish_test;
        if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
        check("pready_pulse", pready, 1'h0);
    endtask

    // ==========================================================
    // Scenarios.
    task t_regs;
        apb(1'h0, `CSP_A_CTRL1, 16'h0000);
        check("ctrl1_reset", rdat, 32'h0000_0000);
        check("pins_off", {bclk_oe_n, fs_oe_n, sdo_oe_n}, 3'h7);
        apb(1'h1, `CSP_A_CTRL2, 16'hFFFF);
        apb(1'h0, `CSP_A_CTRL2, 16'h0000);
        check("ctrl2_fields", rdat, 32'h0000_0DEF);
        apb(1'h1, 12'h040, 16'h1234);
        check("unmapped", rerr, 1'h1);
        apb(1'h1, `CSP_A_RXSLOT, 16'h0001);
        apb(1'h1, `CSP_A_TXSLOT, 16'h0001);
        apb(1'h1, `CSP_A_CLKDIV, 16'h0003);
    endtask

    task t_frame(input logic [15:0] c1, c2, txw, hx, ux, rx);
        int n;
        apb(1'h1, `CSP_A_CTRL1, 16'h0000);
        bits <= {1'h0, c2[3:0]} + 5'h01;
        apb(1'h1, `CSP_A_CTRL2, c2);
        apb(1'h1, TX0, txw);
        apb(1'h1, `CSP_A_CTRL1, c1);
        n = 0;
        while (!c1[11] && heard !== hx && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        if (!c1[11]) check("heard", heard, hx);
        repeat (600) @(posedge pclk);
        if (!c1[11]) check("resend", heard, ux);
        check("pins_driven", {bclk_oe_n, fs_oe_n}, 2'h0);
        apb(1'h0, RX0, 16'h0000);
        check("rx_word", rdat, {16'h0000, rx});
        apb(1'h0, `CSP_A_STATUS, 16'h0000);
        check("tx_underflow", rdat[1], 1'h1);
    endtask

    task t_idle;
        int n;
        logic p;
        apb(1'h1, `CSP_A_CTRL1, 16'hA020);
        for (int k = 0; k < 2; k++) begin
            cpu_idle <= (k == 0);
            repeat (4) @(posedge pclk);
            n = 0;
            p = bclk_o;
            repeat (100) begin
                @(posedge pclk);
                if (bclk_o !== p) n++;
                p = bclk_o;
            end
            check("idle_halt", n == 0, k == 0);
        end
    endtask

    task t_ext;
        apb(1'h1, `CSP_A_CTRL1, 16'h0000);
        ext <= 1'h1;
        bits <= 5'h10;
        apb(1'h1, `CSP_A_CTRL2, 16'h000F);
        apb(1'h1, `CSP_A_CTRL1, 16'h8520);
        repeat (1500) @(posedge pclk);
        check("pins_input", {bclk_oe_n, fs_oe_n}, 2'h3);
        apb(1'h0, RX0, 16'h0000);
        check("ext_rx", rdat, 32'h0000_3C5A);
    endtask

    // ==========================================================
    // Main sequence and timeout.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            finish_test();
        end
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_regs();
        t_frame(16'h80A0, 16'h000F, 16'hA5C3, 16'hA5C3, 16'hA5C3, 16'h3C5A);
        inv <= 1'h1;
        t_frame(16'h82A0, 16'h000F, 16'h1E2D, 16'h1E2D, 16'h1E2D, 16'h3C5A);
        inv <= 1'h0;
        t_frame(16'h8020, 16'h0007, 16'hB7FF, 16'hB700, 16'h0000, 16'h3C00);
        t_frame(16'h88A0, 16'h0007, 16'h5A96, 16'h0000, 16'h0000, 16'h5A00);
        t_idle();
        t_ext();
        finish_test();
    end
endmodule

`default_nettype wire
